//--- verilog/adcst_pkg.sv
// Constants and types for the ADC serial and conversion timing block
package adcst_pkg;
    // Clock period and widths
    localparam int CLK_NS = 10;
    localparam int CMD_W  = 8;
    localparam int RES_W  = 24;
    localparam int CNT_W  = 17;
    localparam int HOLD_W = 10;
    localparam int HI_W   = 5;
    localparam int RLOW_W = 3;
    localparam int CSH_W  = 2;
    localparam int BIT_W  = 3;
    localparam int RCNT_W = 5;
    // Command codes on the serial link
    localparam logic [CMD_W-1:0] CMD_START = 8'h08;
    localparam logic [CMD_W-1:0] CMD_STOP  = 8'h0A;
    localparam logic [CMD_W-1:0] CMD_RESET = 8'h06;
    localparam logic [CMD_W-1:0] CMD_READ  = 8'h12;
    // Timing, master clocks unless named in ns
    localparam int CS_HIGH_NS    = 25;
    localparam int CS_HIGH_CYC   = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_LOW_MIN   = 4;
    localparam int START_PH_MIN  = 4;
    localparam int STOP_SETUP    = 100;
    localparam int STOP_HOLD     = 150;
    localparam int DATA_READY_N_HI_MIN   = 16;
    localparam int RST_TO_CONV   = 512;
    localparam int POR_TO_COMM   = 65536;
    localparam int COMM_TO_CONV  = 512;
    localparam int START_TO_DATA_READY_N = 2;
    localparam int CONV_DEFAULT  = 2000;

    typedef enum logic [1:0] {
        ST_POR  = 2'b00,
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10,
        ST_CONV = 2'b11
    } adcst_state_e;

    // Pin and link levels passing through the synchroniser
    typedef struct packed {
        logic cs1_n;
        logic cs2_n;
        logic start;
        logic rst_n;
        logic tgl;
        logic mode;
        logic tx;
    } adcst_pins_s;

    typedef struct packed {
        logic [BIT_W-1:0]  bits;
        logic [CMD_W-2:0]  shin;
        logic [CMD_W-1:0]  code;
        logic              tgl;
        logic              rd;
        logic [RCNT_W-1:0] rcnt;
    } adcst_link_s;

    typedef struct packed {
        adcst_pins_s       s1;
        adcst_pins_s       s2;
        logic              tgl_seen;
        logic              start_prev;
        logic [RLOW_W-1:0] rlow;
        adcst_state_e      st;
        logic [CNT_W-1:0]  cnt;
        logic [HOLD_W-1:0] hold;
        logic              data_ready_n_n;
        logic [HI_W-1:0]   hi;
        logic              stop_pend;
        logic [CSH_W-1:0]  csh;
        logic [RES_W-1:0]  res;
        logic [RES_W-1:0]  snap;
        logic              pin;
        logic              oe_n;
        logic              rdy;
        logic              conv;
    } adcst_main_s;
endpackage

//--- verilog/adcst_link.sv
// Serial link shifter running on the host serial clock
`timescale 1ns/100ps
module adcst_link (
    // Link clock and interface reset
    input  wire logic                        sclk,
    input  wire logic                        cs_idle,
    // Serial data
    input  wire logic                        din,
    input  wire logic [adcst_pkg::RES_W-1:0] word,
    // Toward the master clock domain
    output logic      [adcst_pkg::CMD_W-1:0] cmd_code,
    output logic                             cmd_tgl,
    output logic                             data_mode,
    output logic                             tx_bit
);
    import adcst_pkg::*;

    adcst_link_s s;
    adcst_link_s n;
    logic        mode_q;
    logic        tx_q;

    // Command shift and read bit count on falling edges
    always_comb begin
        n = s;
        if (s.rd) begin
            n.rcnt = s.rcnt - 5'h01;
            if (s.rcnt == '0) begin
                n.rd = 1'b0;
            end
        end else begin
            n.shin = {s.shin[CMD_W-3:0], din};
            n.bits = s.bits + 3'h1;
            if (s.bits == 3'h7) begin
                n.code = {s.shin, din};
                n.tgl  = ~s.tgl;
                if ({s.shin, din} == CMD_READ) begin
                    n.rd   = 1'b1;
                    n.rcnt = RCNT_W'(RES_W - 1);
                end
            end
        end
    end

    // Both chip selects high clear the interface at once
    always_ff @(negedge sclk or posedge cs_idle) begin
        if (cs_idle) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Output bit and pin function move after rising edges
    always_ff @(posedge sclk or posedge cs_idle) begin
        if (cs_idle) begin
            mode_q <= 1'b0;
            tx_q   <= 1'b0;
        end else begin
            mode_q <= s.rd;
            tx_q   <= word[s.rcnt];
        end
    end

    assign cmd_code  = s.code;
    assign cmd_tgl   = s.tgl;
    assign data_mode = mode_q;
    assign tx_bit    = tx_q;
endmodule

//--- verilog/adcst_top.sv
// Conversion control and serial pin logic on the master clock
`timescale 1ns/100ps
module adcst_top #(
    parameter int POR_CYC  = adcst_pkg::POR_TO_COMM,
    parameter int CONV_CYC = adcst_pkg::CONV_DEFAULT
) (
    // Master clock and power-on reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // Host pins
    input  wire logic                        chip_select_primary_n,
    input  wire logic                        chip_select_secondary_n,
    input  wire logic                        sclk,
    input  wire logic                        din,
    input  wire logic                        start_pin,
    input  wire logic                        reset_pin_n,
    output logic                             serial_out_pin,
    output logic                             serial_out_oe_n,
    // Converter side
    input  wire logic [adcst_pkg::RES_W-1:0] result_data,
    input  wire logic                        cont_mode,
    // Status
    output logic                             data_ready_n,
    output logic                             comm_ready,
    output logic                             converting
);
    import adcst_pkg::*;

    adcst_main_s          s;
    adcst_main_s          n;
    adcst_pins_s          pins_now;
    logic                 cs_idle;
    logic [CMD_W-1:0]     cmd_code;
    logic                 cmd_tgl;
    logic                 data_mode;
    logic                 tx_bit;
    logic                 sel;
    logic                 cmd_evt;
    logic                 start_evt;
    logic                 stop_evt;
    logic                 rst_evt;
    logic                 done;

    // Raw pins form the asynchronous interface reset
    assign cs_idle = chip_select_primary_n & chip_select_secondary_n;

    adcst_link u_link (
        .sclk      (sclk),
        .cs_idle   (cs_idle),
        .din       (din),
        .word      (s.snap),
        .cmd_code  (cmd_code),
        .cmd_tgl   (cmd_tgl),
        .data_mode (data_mode),
        .tx_bit    (tx_bit)
    );

    // Levels entering the first synchroniser stage
    always_comb begin
        pins_now.cs1_n = chip_select_primary_n;
        pins_now.cs2_n = chip_select_secondary_n;
        pins_now.start = start_pin;
        pins_now.rst_n = reset_pin_n;
        pins_now.tgl   = cmd_tgl;
        pins_now.mode  = data_mode;
        pins_now.tx    = tx_bit;
    end

    // Events decoded from synchronised levels
    always_comb begin
        sel      = ~(s.s2.cs1_n & s.s2.cs2_n);
        cmd_evt  = (s.s2.tgl != s.tgl_seen) & sel & s.rdy;
        start_evt = s.rdy & ((s.s2.start & ~s.start_prev)
                   | (cmd_evt & (cmd_code == CMD_START)));
        stop_evt  = s.rdy & ((~s.s2.start & s.start_prev)
                   | (cmd_evt & (cmd_code == CMD_STOP)));
        // Pin reset taken in its fourth low cycle, so a start that
        // rises with the release is not swallowed by a late reset
        rst_evt   = s.rdy & ((cmd_evt & (cmd_code == CMD_RESET))
                   | (~s.s2.rst_n
                      & (s.rlow >= RLOW_W'(RST_LOW_MIN - 1))));
        done      = (s.st == ST_CONV) & (s.cnt == '0)
                   & (s.hi >= HI_W'(DATA_READY_N_HI_MIN)) & ~start_evt;
    end

    // Next state of the whole block
    always_comb begin
        n            = s;
        n.s1         = pins_now;
        n.s2         = s.s1;
        n.tgl_seen   = s.s2.tgl;
        n.start_prev = s.s2.start;
        // Count reset-pin low cycles, saturating at the minimum
        if (s.s2.rst_n) begin
            n.rlow = '0;
        end else if (s.rlow != RLOW_W'(RST_LOW_MIN)) begin
            n.rlow = s.rlow + 3'h1;
        end
        if (s.hold != '0) begin
            n.hold = s.hold - 10'h001;
        end
        // Length of the current ready-high phase
        if (!s.data_ready_n_n) begin
            n.hi = '0;
        end else if (s.hi != HI_W'(DATA_READY_N_HI_MIN)) begin
            n.hi = s.hi + 5'h01;
        end
        // Result snapshot changes only after the link is idle
        if (sel) begin
            n.csh = '0;
        end else if (s.csh != CSH_W'(CS_HIGH_CYC)) begin
            n.csh = s.csh + 2'h1;
        end else begin
            n.snap = s.res;
        end
        case (s.st)
            ST_POR: begin
                n.cnt = s.cnt - 17'h00001;
                if (s.cnt == '0) begin
                    n.st   = ST_IDLE;
                    n.hold = HOLD_W'(COMM_TO_CONV);
                end
            end
            ST_IDLE: begin
                if (start_evt) begin
                    n.data_ready_n_n = 1'b1;
                    n.st     = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (s.hold == '0) begin
                    n.st  = ST_CONV;
                    n.cnt = CNT_W'(CONV_CYC - 1);
                end
            end
            ST_CONV: begin
                if (start_evt) begin
                    n.data_ready_n_n    = 1'b1;
                    n.cnt       = CNT_W'(CONV_CYC - 1);
                    n.stop_pend = 1'b0;
                end else if (s.cnt != '0) begin
                    n.cnt = s.cnt - 17'h00001;
                    if (s.cnt == CNT_W'(DATA_READY_N_HI_MIN)) begin
                        n.data_ready_n_n = 1'b1;
                    end
                end else if (done) begin
                    n.res       = result_data;
                    n.data_ready_n_n    = 1'b0;
                    n.stop_pend = 1'b0;
                    if (cont_mode && !s.stop_pend) begin
                        n.cnt = CNT_W'(CONV_CYC - 1);
                    end else begin
                        n.st = ST_IDLE;
                    end
                end
                // A stop in continuous mode during ST_CONV ends after the conversion in progress
                if (stop_evt && cont_mode && !start_evt) begin
                    n.stop_pend = 1'b1;
                end
            end
            default: n.st = ST_IDLE;
        endcase
        // Hardware reset pin or reset command
        if (rst_evt) begin
            n.st        = ST_IDLE;
            n.data_ready_n_n    = 1'b1;
            n.hold      = HOLD_W'(RST_TO_CONV);
            n.stop_pend = 1'b0;
        end
        // Shared pin function and drive
        n.oe_n = ~sel;
        n.pin  = (sel && s.s2.mode) ? s.s2.tx : n.data_ready_n_n;
        n.rdy  = (n.st != ST_POR);
        n.conv = (n.st == ST_CONV);
        // Synchronous power-on reset
        if (reset) begin
            n          = '0;
            n.s1.cs1_n = 1'b1;
            n.s1.cs2_n = 1'b1;
            n.s2.cs1_n = 1'b1;
            n.s2.cs2_n = 1'b1;
            n.s1.rst_n = 1'b1; // Idle level of the reset pin
            n.s2.rst_n = 1'b1;
            n.st       = ST_POR;
            n.cnt      = CNT_W'(POR_CYC - 1);
            n.data_ready_n_n   = 1'b1;
            n.pin      = 1'b1;
            n.oe_n     = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        s <= n;
    end

    assign serial_out_pin  = s.pin;
    assign serial_out_oe_n = s.oe_n;
    assign data_ready_n    = s.data_ready_n_n;
    assign comm_ready      = s.rdy;
    assign converting      = s.conv;

    // Helper counters watched by the assertions
    logic [HI_W-1:0]  a_hi;
    logic [HOLD_W:0]  a_rst;
    logic [HOLD_W:0]  a_comm;
    logic [CNT_W:0]   a_age;
    always_ff @(posedge clk) begin
        if (reset) begin
            a_hi   <= '0;
            a_rst  <= '0;
            a_comm <= '0;
            a_age  <= '0;
        end else begin
            a_hi   <= !s.data_ready_n_n ? '0 : (a_hi == 5'h1F ? a_hi : a_hi + 5'h01);
            a_rst  <= rst_evt ? '0
                     : (a_rst[HOLD_W] ? a_rst : a_rst + 11'h001);
            a_comm <= !s.rdy ? '0
                     : (a_comm[HOLD_W] ? a_comm : a_comm + 11'h001);
            a_age  <= a_age[CNT_W] ? a_age : a_age + 18'h00001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    data_ready_n_high_min_a: assert property (
        $fell(s.data_ready_n_n) |-> a_hi >= HI_W'(DATA_READY_N_HI_MIN))
        else $error("data ready high phase too short");
    start_data_ready_n_a: assert property (
        start_evt |-> ##[1:2] s.data_ready_n_n)
        else $error("start did not raise data ready in time");
    reset_holdoff_a: assert property (
        $rose(s.conv) |-> a_rst >= 11'(RST_TO_CONV) || a_rst[HOLD_W])
        else $error("conversion started too soon after reset");
    power_up_a: assert property (
        $rose(s.rdy) |-> a_age == 18'(POR_CYC))
        else $error("communication opened at wrong time");
    first_conv_a: assert property (
        $rose(s.conv) |-> a_comm >= 11'(COMM_TO_CONV))
        else $error("first conversion too soon after power-up");
    pin_release_a: assert property (
        !sel |=> s.oe_n)
        else $error("shared pin driven without chip select");
    pin_ready_a: assert property (
        sel && !s.s2.mode |=> s.pin == s.data_ready_n_n)
        else $error("shared pin not showing data ready");
    stop_ends_a: assert property (
        done && s.stop_pend |=> !s.conv ##1 !s.conv)
        else $error("conversion continued after stop");
    cont_runs_a: assert property (
        done && cont_mode && !s.stop_pend && !rst_evt |=> s.conv)
        else $error("continuous conversion not restarted");
    result_ready_a: assert property (
        done && !rst_evt |=> !s.data_ready_n_n && s.res == $past(result_data))
        else $error("result not flagged by data ready");

    start_conv_c: cover property (start_evt ##[1:600] $rose(s.conv));
    ready_fall_c: cover property ($fell(s.data_ready_n_n));
    read_frame_c: cover property (sel && s.s2.mode ##1 !sel);
    stop_late_c:  cover property (
        $fell(s.data_ready_n_n) ##[1:150] stop_evt);
endmodule

//--- test/adcst_host_model.sv
// Behavioural host controller driving the serial link of the converter
`timescale 1ns/100ps
module adcst_host_model (
    // Chip selects and link clock
    output logic      chip_select_primary_n,
    output logic      chip_select_secondary_n,
    output logic      sclk,
    // Serial data
    output logic      din,
    input  wire logic line
);
    localparam realtime HALF = 62.5;

    // Idle: deselected, link clock parked low
    initial begin
        chip_select_primary_n   = 1'b1;
        chip_select_secondary_n = 1'b1;
        sclk                    = 1'b0;
        din                     = 1'b0;
    end

    // Select the device, then leave time for the pin to be driven
    task automatic frame_open(input logic sec);
        if (sec)
            chip_select_secondary_n = 1'b0;
        else
            chip_select_primary_n = 1'b0;
        #60;
    endtask

    // Deselect and keep both selects high long enough to reset the link
    task automatic frame_close();
        #60;
        chip_select_primary_n   = 1'b1;
        chip_select_secondary_n = 1'b1;
        din                     = ~din;
        #100;
    endtask

    // Data launched on rising edge, captured on falling edge, MSB first
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i >= 8 - nbits; i--) begin
            sclk = 1'b1;
            din  = tx[i];
            #HALF;
            rx[i] = line;
            sclk  = 1'b0;
            #HALF;
        end
    endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the conversion timing block
`timescale 1ns/100ps
module tb_top;
    import adcst_pkg::*;
    localparam int          POR    = 200;
    localparam int          CONV   = 300;
    localparam int          LIMIT  = 20000;
    localparam logic [23:0] RESULT = 24'h5A3C96;

    logic        clk;
    logic        reset;
    logic        cs1_n;
    logic        cs2_n;
    logic        sclk;
    logic        din;
    logic        start_pin;
    logic        reset_pin_n;
    logic        serial_out_pin;
    logic        serial_out_oe_n;
    logic [23:0] result_data;
    logic        cont_mode;
    logic        data_ready_n;
    logic        comm_ready;
    logic        converting;
    wire         line;
    int          errors;
    int          total_checks;
    int          cycles;

    // Shared pin level seen by the host
    // Released pin has no pull: show the inverse so late drive shows up
    assign line = serial_out_oe_n ? ~serial_out_pin : serial_out_pin;

    adcst_top #(.POR_CYC(POR), .CONV_CYC(CONV)) dut (
        .clk                     (clk),
        .reset                   (reset),
        .chip_select_primary_n   (cs1_n),
        .chip_select_secondary_n (cs2_n),
        .sclk                    (sclk),
        .din                     (din),
        .start_pin               (start_pin),
        .reset_pin_n             (reset_pin_n),
        .serial_out_pin          (serial_out_pin),
        .serial_out_oe_n         (serial_out_oe_n),
        .result_data             (result_data),
        .cont_mode               (cont_mode),
        .data_ready_n            (data_ready_n),
        .comm_ready              (comm_ready),
        .converting              (converting)
    );

    adcst_host_model host (
        .chip_select_primary_n   (cs1_n),
        .chip_select_secondary_n (cs2_n),
        .sclk                    (sclk),
        .din                     (din),
        .line                    (line)
    );

    // Master clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk_val(string name, logic [23:0] exp, logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_range(string name, int lo, int hi, int got);
        total_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    // Count edges until a status output reaches a level, bounded
    task automatic wait_on(input int sel, input logic lvl, input int limit,
                           output int n);
        logic v;
        n = 0;
        v = ~lvl;
        while (v !== lvl && n < limit) begin
            @(posedge clk);
            #1;
            n++;
            case (sel)
                0:       v = comm_ready;
                1:       v = converting;
                default: v = data_ready_n;
            endcase
        end
        if (v !== lvl) begin
            errors++;
            $display("BAD wait %0d expected %b seen %b", sel, lvl, v);
        end
    endtask

    // Power-up wait, then first start held back by the holdoff
    task automatic t_power();
        int n;
        wait_on(0, 1'b1, POR + 5, n);
        chk_range("power-up wait", POR - 1, POR + 1, n);
        @(posedge clk);
        start_pin <= 1'b1;
        wait_on(1, 1'b1, 700, n);
        chk_range("first conversion delay", 511, 530, n);
        wait_on(2, 1'b0, CONV + 10, n);
        chk_range("conversion length", CONV - 1, CONV + 2, n);
        start_pin <= 1'b0;
    endtask

    // Read the latched result over the link
    task automatic t_read();
        logic [7:0]  rx;
        logic [23:0] word;
        host.frame_open(1'b0);
        chk_val("ready on pin", 24'h000000, {23'h0, line});
        chk_val("pin enable", 24'h000000, {23'h0, serial_out_oe_n});
        host.xfer(CMD_READ, 8, rx);
        host.xfer(8'h00, 8, word[23:16]);
        host.xfer(8'h00, 8, word[15:8]);
        host.xfer(8'h00, 8, word[7:0]);
        chk_val("result word", RESULT, word);
        host.frame_close();
        chk_val("pin released", 24'h000001, {23'h0, serial_out_oe_n});
    endtask

    // Aborted partial command, then start command on the other select
    task automatic t_start_cmd();
        logic [7:0] rx;
        int         n;
        host.frame_open(1'b0);
        host.xfer(8'hF0, 4, rx);
        host.frame_close();
        host.frame_open(1'b1);
        host.xfer(CMD_START, 8, rx);
        wait_on(2, 1'b1, 4, n);
        chk_range("start command to ready", 1, 4, n);
        host.frame_close();
        wait_on(2, 1'b0, CONV + 20, n);
    endtask

    // Reset pin pulse, start pin rises with its release
    task automatic t_reset_pin();
        int n;
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_pin_n <= 1'b1;
        start_pin   <= 1'b1;
        wait_on(1, 1'b1, 700, n);
        chk_range("reset pin holdoff", 512, 530, n);
        wait_on(2, 1'b0, CONV + 10, n);
        start_pin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // Reset command followed by start command in one frame
    task automatic t_reset_cmd();
        logic [7:0] rx;
        int         n;
        host.frame_open(1'b0);
        host.xfer(CMD_RESET, 8, rx);
        fork
            host.xfer(CMD_START, 8, rx);
            wait_on(1, 1'b1, 700, n);
        join
        host.frame_close();
        chk_range("reset command holdoff", 506, 530, n);
        wait_on(2, 1'b0, CONV + 10, n);
    endtask

    // Continuous mode: ready high width, stop shortly after a fall
    task automatic t_cont();
        int n;
        int hits;
        cont_mode <= 1'b1;
        start_pin <= 1'b1;
        wait_on(2, 1'b1, 10, n);
        wait_on(2, 1'b0, CONV + 20, n);
        wait_on(2, 1'b1, CONV, n);
        wait_on(2, 1'b0, 40, n);
        chk_range("ready high width", 16, 18, n);
        repeat (20) @(posedge clk);
        start_pin <= 1'b0;
        wait_on(2, 1'b1, CONV, n);
        wait_on(2, 1'b0, 40, n);
        chk_range("conversion after stop", 16, 18, n);
        hits = 0;
        repeat (2 * CONV) begin
            @(posedge clk);
            #1;
            if (data_ready_n !== 1'b0)
                hits++;
        end
        chk_range("suppressed ready", 0, 0, hits);
        chk_val("converting idle", 24'h000000, {23'h0, converting});
    endtask

    // Main sequence
    initial begin
        errors       = 0;
        total_checks = 0;
        cycles       = 0;
        reset        = 1'b1;
        start_pin    = 1'b0;
        reset_pin_n  = 1'b1;
        cont_mode    = 1'b0;
        result_data  = RESULT;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_power();
        t_read();
        t_start_cmd();
        t_reset_pin();
        t_reset_cmd();
        t_cont();
        complete_run();
    end
endmodule
